/* File: src/usfb_consts.svh */
// register offsets, field positions, reset values and timing counts of the serial block
`ifndef USFB_CONSTS_SVH
`define USFB_CONSTS_SVH
`define USFB_ADDR_DIV_LO 6'h09
`define USFB_ADDR_CTRL_B 6'h0A
`define USFB_ADDR_CTRL_A 6'h0B
`define USFB_ADDR_DATA 6'h0C
`define USFB_ADDR_SHARED 6'h20
`define USFB_SEL_BIT 7
`define USFB_FRAME_RESET 7'h06
`define USFB_DIV_RESET 12'h000
`define USFB_FC_MODE 6
`define USFB_FC_PAR_HI 5
`define USFB_FC_PAR_LO 4
`define USFB_FC_STOP 3
`define USFB_FC_SZ1 2
`define USFB_FC_SZ0 1
`define USFB_FC_POL 0
`define USFB_CB_RXEN 4
`define USFB_CB_TXEN 3
`define USFB_CB_SZ2 2
`define USFB_CB_RX9 1
`define USFB_CB_TX9 0
`define USFB_CA_RXC 7
`define USFB_CA_TXE 5
`define USFB_CA_PE 2
`define USFB_CA_DBL 1
`define USFB_OVS_NORMAL 4'hF
`define USFB_OVS_DOUBLE 4'h7
`define USFB_OVS_SYNC 4'h1
`endif

/* File: src/usfb_pkg.sv */
// state types of the serial block
`default_nettype none
package usfb_pkg;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP1 = 3'b100,
      TX_STOP2 = 3'b101
   } usfb_tx_e;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } usfb_rx_e;
endpackage
`default_nettype wire

/* File: src/usfb_top.sv */
// serial transceiver with frame format and baud divisor registers on the I/O bus
`timescale 1ns/1ps
`default_nettype none
`include "usfb_consts.svh"
module usfb_top
   import usfb_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   // I/O bus
   input wire logic [ADDR_W-1:0] IO_ADDR_I,
   input wire logic [7:0] IO_WDATA_I,
   input wire logic IO_WR_I,
   input wire logic IO_RD_I,
   output logic [7:0] IO_RDATA_O,
   // serial lines
   input wire logic RXD_I,
   output logic TXD_O,
   output logic XCK_O
);
   if (ADDR_W < 6) begin : g_bad_addr
      $error("usfb_top: ADDR_W must be at least 6");
   end

   localparam logic [ADDR_W-1:0] A_DIV_LO = ADDR_W'(`USFB_ADDR_DIV_LO);
   localparam logic [ADDR_W-1:0] A_CTRL_B = ADDR_W'(`USFB_ADDR_CTRL_B);
   localparam logic [ADDR_W-1:0] A_CTRL_A = ADDR_W'(`USFB_ADDR_CTRL_A);
   localparam logic [ADDR_W-1:0] A_DATA = ADDR_W'(`USFB_ADDR_DATA);
   localparam logic [ADDR_W-1:0] A_SHARED = ADDR_W'(`USFB_ADDR_SHARED);

   logic [6:0] frame_r;
   logic [3:0] div_hi_r;
   logic [7:0] div_lo_r;
   logic dbl_r, rxen_r, txen_r, sz2_r, tx9_r;
   logic shared_rd_r;
   logic [7:0] rdata_r;
   logic [11:0] div_cnt_r;
   logic [3:0] phase_r;
   logic xck_r, txd_r;
   usfb_tx_e tx_state_r;
   logic tx_pend_r;
   logic [3:0] tx_idx_r;
   logic [8:0] tx_shift_r;
   logic rxd_meta_r, rxd_sync_r;
   usfb_rx_e rx_state_r;
   logic [3:0] rx_cnt_r, rx_idx_r;
   logic [8:0] rx_data_r;
   logic rx_par_r, rx_perr_r, rx_done_r;
   logic [8:0] rx_buf_r;
   logic rxc_r, pe_r;

   logic wr_shared, wr_lo, wr_data, rd_data;
   logic sync_mode, pol, par_en, par_odd, stop2;
   logic [11:0] baud_divisor;
   logic [3:0] nbits, ovs_last, rx_tgt;
   logic tick, bit_end, rx_smp, tx_load;
   logic [8:0] data_mask;
   logic tx_par_bit;
   logic [3:0] phase_nxt;

   assign wr_shared = IO_WR_I && (IO_ADDR_I == A_SHARED);
   assign wr_lo = IO_WR_I && (IO_ADDR_I == A_DIV_LO);
   assign wr_data = IO_WR_I && (IO_ADDR_I == A_DATA);
   assign rd_data = IO_RD_I && (IO_ADDR_I == A_DATA);
   assign sync_mode = frame_r[`USFB_FC_MODE];
   assign pol = frame_r[`USFB_FC_POL];
   // reserved parity code 01 behaves as disabled
   assign par_en = frame_r[`USFB_FC_PAR_HI];
   assign par_odd = frame_r[`USFB_FC_PAR_LO];
   assign stop2 = frame_r[`USFB_FC_STOP];
   assign baud_divisor = {div_hi_r, div_lo_r};

   // reserved size codes fall back to eight bits
   always_comb begin
      case ({sz2_r, frame_r[`USFB_FC_SZ1], frame_r[`USFB_FC_SZ0]})
         3'b000: nbits = 4'h5;
         3'b001: nbits = 4'h6;
         3'b010: nbits = 4'h7;
         3'b111: nbits = 4'h9;
         default: nbits = 4'h8;
      endcase
   end

   // double speed only matters in async mode
   assign ovs_last = sync_mode ? `USFB_OVS_SYNC :
                     (dbl_r ? `USFB_OVS_DOUBLE : `USFB_OVS_NORMAL);

   genvar gi;
   for (gi = 0; gi < 9; gi++) begin : g_mask
      assign data_mask[gi] = (4'(gi) < nbits);
   end
   assign tx_par_bit = (^(tx_shift_r & data_mask)) ^ par_odd;

   // register writes
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         frame_r <= `USFB_FRAME_RESET;
         div_hi_r <= 4'(`USFB_DIV_RESET >> 8);
         div_lo_r <= 8'h00;
         dbl_r <= 1'b0;
         rxen_r <= 1'b0;
         txen_r <= 1'b0;
         sz2_r <= 1'b0;
         tx9_r <= 1'b0;
      end else if (IO_WR_I) begin
         if (wr_shared && IO_WDATA_I[`USFB_SEL_BIT]) begin
            frame_r <= IO_WDATA_I[6:0];
         end else if (wr_shared) begin
            // bits 6:4 are reserved and not stored
            div_hi_r <= IO_WDATA_I[3:0];
         end
         if (wr_lo) begin
            div_lo_r <= IO_WDATA_I;
         end
         if (IO_ADDR_I == A_CTRL_A) begin
            dbl_r <= IO_WDATA_I[`USFB_CA_DBL];
         end
         if (IO_ADDR_I == A_CTRL_B) begin
            rxen_r <= IO_WDATA_I[`USFB_CB_RXEN];
            txen_r <= IO_WDATA_I[`USFB_CB_TXEN];
            sz2_r <= IO_WDATA_I[`USFB_CB_SZ2];
            tx9_r <= IO_WDATA_I[`USFB_CB_TX9];
         end
      end
   end

   // shared read: high byte first, frame register when the read directly follows one
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         shared_rd_r <= 1'b0;
      end else if (IO_RD_I || IO_WR_I) begin
         shared_rd_r <= IO_RD_I && (IO_ADDR_I == A_SHARED) && !shared_rd_r;
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         rdata_r <= 8'h00;
      end else if (IO_RD_I) begin
         case (IO_ADDR_I)
            A_SHARED: rdata_r <= shared_rd_r ? {1'b1, frame_r} : {4'h0, div_hi_r};
            A_DIV_LO: rdata_r <= div_lo_r;
            A_CTRL_A: rdata_r <= {rxc_r, 1'b0, !tx_pend_r && tx_state_r == TX_IDLE,
                                  2'b00, pe_r, dbl_r, 1'b0};
            A_CTRL_B: rdata_r <= {3'b000, rxen_r, txen_r, sz2_r, rx_buf_r[8], tx9_r};
            A_DATA: rdata_r <= rx_buf_r[7:0];
            default: rdata_r <= 8'h00;
         endcase
      end
   end
   assign IO_RDATA_O = rdata_r;

   // prescaler: one tick every divisor plus one clocks
   assign tick = (div_cnt_r == 12'h000);
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         div_cnt_r <= `USFB_DIV_RESET;
         phase_r <= 4'h0;
      end else if (wr_lo) begin
         div_cnt_r <= {div_hi_r, IO_WDATA_I};
         phase_r <= 4'h0;
      end else if (tick) begin
         div_cnt_r <= baud_divisor;
         phase_r <= (phase_r >= ovs_last) ? 4'h0 : 4'(phase_r + 4'h1);
      end else begin
         div_cnt_r <= 12'(div_cnt_r - 12'h001);
      end
   end
   assign bit_end = tick && (phase_r >= ovs_last);
   assign phase_nxt = (wr_lo || bit_end) ? 4'h0 : (tick ? 4'(phase_r + 4'h1) : phase_r);

   // sync clock follows the next phase, so its launching edge meets the data change
   // instead of trailing it by one system clock
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         xck_r <= 1'b0;
      end else begin
         xck_r <= sync_mode ? ((phase_nxt == 4'h0) ^ pol) : 1'b0;
      end
   end
   assign XCK_O = xck_r;

   // transmitter; a write while busy is dropped
   assign tx_load = wr_data && txen_r && !tx_pend_r && tx_state_r == TX_IDLE;
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         tx_state_r <= TX_IDLE;
         tx_pend_r <= 1'b0;
         tx_idx_r <= 4'h0;
         tx_shift_r <= 9'h000;
         txd_r <= 1'b1;
      end else begin
         if (tx_load) begin
            tx_shift_r <= {tx9_r, IO_WDATA_I};
            tx_pend_r <= 1'b1;
         end
         if (bit_end) begin
            case (tx_state_r)
               TX_IDLE: begin
                  if (tx_pend_r) begin
                     tx_state_r <= TX_START;
                     tx_pend_r <= 1'b0;
                     txd_r <= 1'b0;
                  end
               end
               TX_START: begin
                  tx_state_r <= TX_DATA;
                  tx_idx_r <= 4'h0;
                  txd_r <= tx_shift_r[0];
               end
               TX_DATA: begin
                  if (tx_idx_r == 4'(nbits - 4'h1)) begin
                     tx_state_r <= par_en ? TX_PAR : TX_STOP1;
                     txd_r <= par_en ? tx_par_bit : 1'b1;
                  end else begin
                     tx_idx_r <= 4'(tx_idx_r + 4'h1);
                     txd_r <= tx_shift_r[4'(tx_idx_r + 4'h1)];
                  end
               end
               TX_PAR: begin
                  tx_state_r <= TX_STOP1;
                  txd_r <= 1'b1;
               end
               TX_STOP1: tx_state_r <= stop2 ? TX_STOP2 : TX_IDLE;
               TX_STOP2: tx_state_r <= TX_IDLE;
               default: tx_state_r <= TX_IDLE;
            endcase
         end
      end
   end
   assign TXD_O = txd_r;

   // receive line synchroniser
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         rxd_meta_r <= 1'b1;
         rxd_sync_r <= 1'b1;
      end else begin
         rxd_meta_r <= RXD_I;
         rxd_sync_r <= rxd_meta_r;
      end
   end

   // async samples mid-bit from the start edge; sync samples on the sampling edge
   assign rx_tgt = (rx_state_r == RX_START) ? (ovs_last >> 1) : ovs_last;
   assign rx_smp = sync_mode ? (tick && phase_r == 4'h0) : (tick && rx_cnt_r == rx_tgt);

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         rx_state_r <= RX_IDLE;
         rx_cnt_r <= 4'h0;
         rx_idx_r <= 4'h0;
         rx_data_r <= 9'h000;
         rx_par_r <= 1'b0;
         rx_perr_r <= 1'b0;
         rx_done_r <= 1'b0;
      end else begin
         rx_done_r <= 1'b0;
         if (tick && rx_state_r != RX_IDLE) begin
            rx_cnt_r <= rx_smp ? 4'h0 : 4'(rx_cnt_r + 4'h1);
         end
         case (rx_state_r)
            RX_IDLE: begin
               rx_cnt_r <= 4'h0;
               if (rxen_r && !rxd_sync_r && !sync_mode && tick) begin
                  rx_state_r <= RX_START;
               end else if (rxen_r && !rxd_sync_r && rx_smp) begin
                  rx_state_r <= RX_DATA;
                  rx_idx_r <= 4'h0;
                  rx_data_r <= 9'h000;
                  rx_par_r <= 1'b0;
                  rx_perr_r <= 1'b0;
               end
            end
            RX_START: begin
               if (rx_smp) begin
                  rx_state_r <= rxd_sync_r ? RX_IDLE : RX_DATA;
                  rx_idx_r <= 4'h0;
                  rx_data_r <= 9'h000;
                  rx_par_r <= 1'b0;
                  rx_perr_r <= 1'b0;
               end
            end
            RX_DATA: begin
               if (rx_smp) begin
                  rx_data_r[rx_idx_r] <= rxd_sync_r;
                  rx_par_r <= rx_par_r ^ rxd_sync_r;
                  if (rx_idx_r == 4'(nbits - 4'h1)) begin
                     rx_state_r <= par_en ? RX_PAR : RX_STOP;
                  end else begin
                     rx_idx_r <= 4'(rx_idx_r + 4'h1);
                  end
               end
            end
            RX_PAR: begin
               if (rx_smp) begin
                  rx_perr_r <= rx_par_r ^ rxd_sync_r ^ par_odd;
                  rx_state_r <= RX_STOP;
               end
            end
            // one stop bit is sampled whatever the stop setting
            RX_STOP: begin
               if (rx_smp) begin
                  rx_state_r <= RX_IDLE;
                  rx_done_r <= 1'b1;
               end
            end
            default: rx_state_r <= RX_IDLE;
         endcase
      end
   end

   // single-entry receive buffer; a new frame wins over a clearing read
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         rx_buf_r <= 9'h000;
         rxc_r <= 1'b0;
         pe_r <= 1'b0;
      end else if (rx_done_r) begin
         rx_buf_r <= rx_data_r;
         rxc_r <= 1'b1;
         pe_r <= rx_perr_r;
      end else if (rd_data || !rxen_r) begin
         rxc_r <= 1'b0;
         pe_r <= 1'b0;
      end
   end

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);

   sequence s_shared_rd_first;
      IO_RD_I && IO_ADDR_I == A_SHARED && !shared_rd_r;
   endsequence
   sequence s_launch;
      sync_mode && !pol && bit_end && tx_state_r != TX_IDLE;
   endsequence
   sequence s_shared_rd_pair;
      s_shared_rd_first ##1 (!IO_RD_I && !IO_WR_I) ##1 (IO_RD_I && IO_ADDR_I == A_SHARED);
   endsequence

   chk_shared_rd_frame: assert property (s_shared_rd_pair
      |=> IO_RDATA_O == {1'b1, frame_r})
      else $error("frame read lacks select bit");
   chk_shared_rd_high: assert property (s_shared_rd_first |=> IO_RDATA_O[7:4] == 4'h0)
      else $error("high byte read shows upper bits");
   chk_shared_wr_route: assert property (wr_shared && !IO_WDATA_I[7] |=> $stable(frame_r))
      else $error("high byte write disturbed frame register");
   chk_lo_reload: assert property (wr_lo |=> div_cnt_r == {div_hi_r, $past(IO_WDATA_I)})
      else $error("prescaler not reloaded");
   chk_stop_one: assert property (bit_end && tx_state_r == TX_STOP1 && !stop2
      |=> tx_state_r == TX_IDLE && TXD_O)
      else $error("extra stop bit sent");
   chk_tx_parity: assert property (bit_end && tx_state_r == TX_DATA && par_en
      && tx_idx_r == 4'(nbits - 4'h1) |=> TXD_O == tx_par_bit)
      else $error("parity bit wrong");
   chk_rx_perr: assert property (rx_done_r |=> pe_r == $past(rx_perr_r) && rxc_r)
      else $error("parity error flag not captured");
   chk_sync_edge: assert property (s_launch |=> $rose(XCK_O))
      else $error("sync data change off the rising edge");
   chk_upper_zero: assert property (rx_done_r && nbits == 4'h5 |=> rx_buf_r[8:5] == 4'h0)
      else $error("unused receive bits not zero");
   chk_async_ovs: assert property (!sync_mode && dbl_r && bit_end |-> phase_r == 4'h7)
      else $error("double speed oversampling wrong");
endmodule
`default_nettype wire

/* File: sim/usfb_remote.sv */
// remote serial station: frame catcher on the transmit line, frame sender on the receive line
`timescale 1ns/1ps
`default_nettype none
module usfb_remote (
   // clock
   input wire logic clk_i,
   // capture control
   input wire logic arm_i,
   input wire logic [7:0] bit_clks_i,
   input wire logic [4:0] cap_len_i,
   output logic got_o,
   output logic [15:0] cap_o,
   // serial lines
   input wire logic txd_i,
   output logic rxd_o
);
   initial begin
      rxd_o = 1'b1;
      got_o = 1'b0;
      cap_o = 16'h0000;
   end
   // samples mid-bit, so a wrong bit period walks the samples onto wrong bits
   always begin
      wait (arm_i === 1'b1);
      @(negedge txd_i);
      repeat (bit_clks_i / 2) @(posedge clk_i);
      for (int i = 0; i < int'(cap_len_i); i++) begin
         #1;
         cap_o[i] = txd_i;
         repeat (bit_clks_i) @(posedge clk_i);
      end
      got_o = 1'b1;
      wait (arm_i === 1'b0);
      got_o = 1'b0;
   end
   // drives bit 0 first; the line returns to its idle high level afterwards
   task automatic send(input logic [15:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         rxd_o = bits[i];
         repeat (bit_clks_i) @(posedge clk_i);
      end
      rxd_o = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the serial block with frame format and baud divisor registers
`timescale 1ns/1ps
`default_nettype none
`include "usfb_consts.svh"
module tb_top;
   logic clk, rst, wr, rd, txd, rxd, sync_clock_pin, arm, got;
   logic [5:0] addr;
   logic [7:0] wdata, rdata, bclk;
   logic [4:0] clen;
   logic [15:0] cap;
   int fails = 0;
   int check_count = 0;

   usfb_top usfb_top_inst (.CLOCK_I(clk), .RESET_I(rst), .IO_ADDR_I(addr), .IO_WDATA_I(wdata),
      .IO_WR_I(wr), .IO_RD_I(rd), .IO_RDATA_O(rdata), .RXD_I(rxd), .TXD_O(txd), .XCK_O(sync_clock_pin));
   usfb_remote usfb_remote_inst (.clk_i(clk), .arm_i(arm), .bit_clks_i(bclk), .cap_len_i(clen),
      .got_o(got), .cap_o(cap), .txd_i(txd), .rxd_o(rxd));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask
   // strobes stay low one cycle between accesses so no signal is set twice in a step
   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk) #1;
      wr = 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
      addr = a;
      rd = 1'b1;
      @(posedge clk) #1;
      rd = 1'b0;
      d = rdata;
      @(posedge clk) #1;
   endtask
   task automatic wait_flag(input int b);
      logic [7:0] v;
      for (int i = 0; i < 2000; i++) begin
         io_rd(`USFB_ADDR_CTRL_A, v);
         if (v[b] === 1'b1) return;
      end
      chk(16'h0000, 16'h0001, "flag wait");
   endtask
   task automatic cfg(input logic [7:0] fr, input logic [7:0] cb, input logic [7:0] ca,
         input logic [7:0] lo);
      io_wr(`USFB_ADDR_SHARED, fr);
      io_wr(`USFB_ADDR_SHARED, 8'h00);
      io_wr(`USFB_ADDR_DIV_LO, lo);
      io_wr(`USFB_ADDR_CTRL_B, cb);
      io_wr(`USFB_ADDR_CTRL_A, ca);
   endtask
   function automatic logic [15:0] mk_frame(input logic [8:0] d, input int n,
         input logic [1:0] pm, input int stops);
      logic [15:0] e;
      int len;
      e = 16'h0000;
      len = n + 1 + int'(pm[1]);
      for (int i = 0; i < n; i++) e[i+1] = d[i];
      if (pm[1]) e[n+1] = pm[0] ^ (^(d & ((9'h001 << n) - 9'h001)));
      for (int i = 0; i < stops; i++) e[len+i] = 1'b1;
      return e;
   endfunction
   // two characters in a row: with no transmit buffer the second start bit follows
   // exactly one idle bit after the last stop
   task automatic tx_pair(input logic [8:0] d, input int n, input logic [1:0] pm,
         input int stops, input int bc);
      int len;
      len = 1 + n + int'(pm[1]) + stops;
      bclk = bc[7:0];
      clen = 5'(len + 2);
      arm = 1'b1;
      io_wr(`USFB_ADDR_DATA, d[7:0]);
      wait_flag(`USFB_CA_TXE);
      io_wr(`USFB_ADDR_DATA, d[7:0]);
      for (int i = 0; i < 3000 && got !== 1'b1; i++) @(posedge clk);
      #1;
      chk(got, 1'b1, "tx capture done");
      chk(cap & 16'((32'h1 << (len + 2)) - 1), mk_frame(d, n, pm, stops) | 16'(32'h1 << len),
         "tx frame");
      arm = 1'b0;
      repeat ((len + 1) * bc) @(posedge clk);
      #1;
   endtask

   task automatic t_reset();
      logic [7:0] hi, fr;
      io_rd(`USFB_ADDR_SHARED, hi);
      io_rd(`USFB_ADDR_SHARED, fr);
      chk(hi, 8'h00, "high byte at reset");
      chk(fr, 8'h86, "frame at reset");
      chk(sync_clock_pin, 1'b0, "sync clock in async");
      io_wr(6'h15, 8'hFF);
      io_rd(6'h15, hi);
      chk(hi, 8'h00, "unmapped read");
      $display("test reset done");
   endtask
   task automatic t_shared();
      logic [7:0] hi, fr;
      io_wr(`USFB_ADDR_SHARED, 8'h0A);
      io_wr(`USFB_ADDR_SHARED, 8'hBE);
      io_rd(`USFB_ADDR_SHARED, hi);
      io_rd(`USFB_ADDR_SHARED, fr);
      chk(hi, 8'h0A, "high byte");
      chk(fr, 8'hBE, "frame");
      $display("test shared done");
   endtask
   task automatic t_tx();
      cfg(8'hAE, 8'h08, 8'h00, 8'h01);
      tx_pair(9'h0A5, 8, 2'b10, 2, 32);
      cfg(8'hB6, 8'h0D, 8'h02, 8'h01);
      tx_pair(9'h13C, 9, 2'b11, 1, 16);
      cfg(8'h90, 8'h08, 8'h00, 8'h00);
      tx_pair(9'h0F5, 5, 2'b00, 1, 16);
      $display("test transmit done");
   endtask
   task automatic t_rx();
      logic [7:0] v;
      cfg(8'hA6, 8'h10, 8'h00, 8'h01);
      bclk = 8'h20;
      for (int k = 0; k < 2; k++) begin
         usfb_remote_inst.send(mk_frame(9'h05A, 8, 2'b10, 1) ^ (16'(k) << 9), 11);
         wait_flag(`USFB_CA_RXC);
         io_rd(`USFB_ADDR_CTRL_A, v);
         chk(v & 8'h04, 8'(k << 2), "parity flag");
         io_rd(`USFB_ADDR_DATA, v);
         chk(v, 8'h5A, "rx data");
      end
      cfg(8'hA0, 8'h10, 8'h00, 8'h01);
      usfb_remote_inst.send(mk_frame(9'h015, 5, 2'b10, 1), 8);
      wait_flag(`USFB_CA_RXC);
      io_rd(`USFB_ADDR_DATA, v);
      chk(v, 8'h15, "short rx data");
      $display("test receive done");
   endtask
   task automatic t_sync();
      logic pt, px;
      int tg;
      for (int p = 0; p < 2; p++) begin
         cfg(8'hC6 | 8'(p), 8'h08, 8'h00, 8'h01);
         io_wr(`USFB_ADDR_DATA, 8'h55);
         pt = txd;
         px = sync_clock_pin;
         tg = 0;
         repeat (80) begin
            @(posedge clk) #1;
            if (sync_clock_pin !== px) tg++;
            if (txd !== pt) chk({sync_clock_pin, px}, p[0] ? 2'b01 : 2'b10, "launch edge");
            pt = txd;
            px = sync_clock_pin;
         end
         chk(tg > 0, 1'b1, "sync clock runs");
         repeat (100) @(posedge clk);
         #1;
      end
      $display("test sync done");
   endtask

   task automatic finish_test();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("[FAIL] %0t watchdog", $time);
      finish_test();
   end
   initial begin
      rst = 1'b1;
      addr = 6'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      arm = 1'b0;
      bclk = 8'h10;
      clen = 5'h01;
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_shared();
      t_tx();
      t_rx();
      t_sync();
      finish_test();
   end
endmodule
`default_nettype wire
